// >>> pkg/ssim_pkg.sv
// Purpose: constants shared by the substitute sensor input monitor
// Assumes: 32-bit register port, byte addresses on word boundaries
// Notes:   none
package ssim_pkg;

  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned SENSOR_N      = 8;
  localparam int unsigned PORT_N        = 4;
  localparam int unsigned NODE_W        = 6;
  localparam int unsigned PSEL_W        = 2;
  localparam int unsigned LIMIT_W       = 4;
  localparam int unsigned CNT_W         = 8;
  localparam int unsigned CMD_W         = 16;

  // register byte addresses
  localparam logic [7:0]  ADDR_CONFIG   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_COMMAND  = 8'h08;
  localparam logic [7:0]  ADDR_VIEW     = 8'h0C;

  // config fields
  localparam int unsigned NODE_LSB      = 0;
  localparam int unsigned PSEL_LSB      = 6;
  localparam int unsigned SEL_LSB       = 8;
  localparam int unsigned LIMIT_LSB     = 24;

  // status fields
  localparam int unsigned ST_RUN_LSB    = 0;
  localparam int unsigned ST_FLAG_BIT   = 8;
  localparam int unsigned ST_CNT_LSB    = 16;

  // view fields
  localparam int unsigned VW_SENS_LSB   = 0;
  localparam int unsigned VW_REM_LSB    = 8;
  localparam int unsigned VW_SEEN_BIT   = 16;

  // reset values and limits
  localparam logic [31:0] CONFIG_RST    = 32'h0000_0000;
  localparam logic [7:0]  CNT_RST       = 8'h00;
  localparam logic [7:0]  CNT_MAX       = 8'hFF;
  localparam logic [3:0]  RUN_RST       = 4'h0;
  localparam logic [7:0]  REMOTE_RST    = 8'h00;
  localparam logic [15:0] CMD_CLR_ERRCNT = 16'h0032;

endpackage : ssim_pkg

// >>> pkg/ssim_sel_if.sv
// Purpose: carrier between monitor core and source selector
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/1ns
interface ssim_sel_if;
  logic [7:0] pin_sync;
  logic [7:0] remote_byte;
  logic [7:0] source_sel;
  logic [7:0] sensor;

  modport core (output pin_sync, output remote_byte, output source_sel, input sensor);
  modport sel  (input pin_sync, input remote_byte, input source_sel, output sensor);
endinterface : ssim_sel_if

// >>> rtl/ssim_sel.sv
// Purpose: per-signal choice between local pin and remote port bit
// Assumes: pins already synchronised by the caller
// Notes:   result feeds the existing filter and inversion stage
`timescale 1ns/1ns
module ssim_sel (
  input  wire logic clock,
  input  wire logic rst_b,
  ssim_sel_if.sel   sif
);

  logic [7:0] sensor_r;
  logic [7:0] sensor_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // bit order: fwd, rev, slowdown, origin, emergency, alarm, go, halt
  // bit 0 forward limit, see RULE3
  // bit 1 reverse limit, see RULE4
  // bit 2 slowdown, see RULE5
  // bit 3 origin, see RULE6
  // bit 4 emergency, see RULE7
  // bit 5 alarm, see RULE8
  // bit 6 external go, see RULE9
  // bit 7 external halt, see RULE10
  // switch sits right after the pin buffer, see RULE11
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_mux
      always_comb begin
        sensor_nxt[gi] = sif.source_sel[gi] ? sif.remote_byte[gi] : sif.pin_sync[gi];
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sensor_r <= 8'h00;
    end else begin
      sensor_r <= sensor_nxt;
    end
  end

  assign sif.sensor = sensor_r;

  ////////////////////////////////////////////////////////////////////////////
  a_fwd_src_pick: assert property ( // see RULE3
    @(posedge clock) disable iff (!rst_b)
    sensor_r[0] == ($past(sif.source_sel[0]) ? $past(sif.remote_byte[0])
                                             : $past(sif.pin_sync[0])))
    else $error("forward limit source mismatch");

  a_halt_src_pick: assert property ( // see RULE10
    @(posedge clock) disable iff (!rst_b)
    (!sif.source_sel[7] && $stable(sif.source_sel[7])) |=>
      sensor_r[7] == $past(sif.pin_sync[7]))
    else $error("halt input not taken from pin");

endmodule : ssim_sel

// >>> rtl/ssim_top.sv
// Purpose: substitute sensor inputs from a remote node, with error watch
// Assumes: receive path and period tick come from logic on this clock
// Notes:   sensor pins are asynchronous and synchronised here
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns

// Overview of operation
// RULE1: software picks remote node 0 to 63
// RULE2: software picks remote port 0 to 3
// RULE3: forward limit from pin or port bit 0
// RULE4: reverse limit from pin or port bit 1
// RULE5: slowdown from pin or port bit 2
// RULE6: origin from pin or port bit 3
// RULE7: emergency from pin or port bit 4
// RULE8: alarm from pin or port bit 5
// RULE9: external go from pin or bit 6
// RULE10: external halt from pin or bit 7
// RULE11: switch after pin buffer, before filtering
// RULE12: remote value taken from observed cyclic data
// RULE13: error counter saturates at 255
// RULE14: command 0032h clears the error counter
// RULE15: 4-bit limit, zero disables error stop
// RULE16: reaching limit stops motor, sets flag
// RULE17: one good period restarts consecutive count
// RULE18: software should use nonzero limit
// RULE19: reset clears the error counter
// RULE20: missed period counts error, holds value
module ssim_top (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        forward_limit_input,
  input  wire logic        reverse_limit_input,
  input  wire logic        slowdown_input,
  input  wire logic        origin_sensor_input,
  input  wire logic        emergency_halt_input,
  input  wire logic        alarm_input,
  input  wire logic        external_go_input,
  input  wire logic        external_halt_input,
  input  wire logic        rx_valid,
  input  wire logic [5:0]  rx_node,
  input  wire logic [31:0] rx_port_data,
  input  wire logic        cycle_tick,
  output logic [7:0]       sensor_out,
  output logic             error_stop,
  output logic             error_flag
);

  ssim_sel_if sif ();

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  logic [7:0] pin_raw;
  logic [7:0] pin_meta_r;
  logic [7:0] pin_sync_r;

  assign pin_raw = {external_halt_input, external_go_input, alarm_input,
                    emergency_halt_input, origin_sensor_input, slowdown_input,
                    reverse_limit_input, forward_limit_input};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_r <= 8'h00;
      pin_sync_r <= 8'h00;
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
    hit = (a == base);
  endfunction : hit

  logic [31:0] config_r;
  logic [31:0] config_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        clr_cmd;
  logic        flag_w1c;

  logic [5:0]  node_sel;
  logic [1:0]  port_sel;
  logic [7:0]  source_sel;
  logic [3:0]  err_limit;

  assign node_sel   = config_r[ssim_pkg::NODE_LSB +: ssim_pkg::NODE_W];   // see RULE1
  assign port_sel   = config_r[ssim_pkg::PSEL_LSB +: ssim_pkg::PSEL_W];   // see RULE2
  assign source_sel = config_r[ssim_pkg::SEL_LSB  +: ssim_pkg::SENSOR_N];
  assign err_limit  = config_r[ssim_pkg::LIMIT_LSB +: ssim_pkg::LIMIT_W]; // see RULE15

  assign clr_cmd  = reg_wr && hit(reg_addr, ssim_pkg::ADDR_COMMAND)
                    && (reg_wdata[15:0] == ssim_pkg::CMD_CLR_ERRCNT);     // see RULE14
  assign flag_w1c = reg_wr && hit(reg_addr, ssim_pkg::ADDR_STATUS)
                    && reg_wdata[ssim_pkg::ST_FLAG_BIT];

  always_comb begin
    config_nxt = config_r;
    if (reg_wr && hit(reg_addr, ssim_pkg::ADDR_CONFIG)) begin
      config_nxt = reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      config_r <= ssim_pkg::CONFIG_RST;
    end else begin
      config_r <= config_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // remote port observation
  logic [7:0] remote_r;
  logic [7:0] remote_nxt;
  logic       seen_r;
  logic       seen_nxt;
  logic       frame_ok;
  logic       watching;

  // only frames from the chosen node count; others are ignored
  assign frame_ok = rx_valid && (rx_node == node_sel);                    // see RULE12
  // no substitute in use means nothing to watch, so no errors pile up
  assign watching = |source_sel;

  always_comb begin
    remote_nxt = remote_r;
    seen_nxt   = seen_r;
    if (frame_ok) begin
      remote_nxt = rx_port_data[port_sel * 8 +: 8];                       // see RULE2
    end
    if (cycle_tick) begin
      seen_nxt = 1'b0;
    end else if (frame_ok) begin
      seen_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      remote_r <= ssim_pkg::REMOTE_RST;
      seen_r   <= 1'b0;
    end else begin
      remote_r <= remote_nxt;                                             // see RULE20
      seen_r   <= seen_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error counting and error stop
  logic [7:0] errcnt_r;
  logic [7:0] errcnt_nxt;
  logic [3:0] run_r;
  logic [3:0] run_nxt;
  logic       stop_r;
  logic       stop_nxt;
  logic       flag_r;
  logic       flag_nxt;
  logic       period_ok;
  logic       period_err;
  logic [3:0] run_inc;

  // a frame in the tick cycle itself still counts for the closing period
  assign period_ok  = seen_r || frame_ok;
  assign period_err = cycle_tick && watching && !period_ok;               // see RULE20
  assign run_inc    = run_r + 4'h1;

  always_comb begin
    errcnt_nxt = errcnt_r;
    run_nxt    = run_r;
    stop_nxt   = 1'b0;
    flag_nxt   = flag_r;
    if (clr_cmd) begin
      errcnt_nxt = ssim_pkg::CNT_RST;                                     // see RULE14
    end
    if (period_err && (errcnt_r != ssim_pkg::CNT_MAX)) begin
      // a clear and an increment in the same cycle below 255 give 1: the error is not lost
      errcnt_nxt = clr_cmd ? 8'h01 : errcnt_r + 8'h01;                    // see RULE13
    end
    if (cycle_tick && period_ok) begin
      run_nxt = ssim_pkg::RUN_RST;                                        // see RULE17
    end else if (period_err) begin
      if ((err_limit != 4'h0) && (run_inc == err_limit)) begin
        run_nxt  = ssim_pkg::RUN_RST;
        stop_nxt = 1'b1;                                                  // see RULE16
      end else if (err_limit != 4'h0) begin
        run_nxt = run_inc;
      end else begin
        run_nxt = ssim_pkg::RUN_RST;                                      // see RULE15
      end
    end
    if (flag_w1c) begin
      flag_nxt = 1'b0;
    end
    if (stop_nxt) begin
      flag_nxt = 1'b1;                                                    // see RULE16
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      errcnt_r <= ssim_pkg::CNT_RST;                                      // see RULE19
      run_r    <= ssim_pkg::RUN_RST;
      stop_r   <= 1'b0;
      flag_r   <= 1'b0;
    end else begin
      errcnt_r <= errcnt_nxt;
      run_r    <= run_nxt;
      stop_r   <= stop_nxt;
      flag_r   <= flag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection
  assign sif.pin_sync    = pin_sync_r;
  assign sif.remote_byte = remote_r;
  assign sif.source_sel  = source_sel;

  ssim_sel u_sel (
    .clock (clock),
    .rst_b (rst_b),
    .sif   (sif.sel)
  );

  assign sensor_out = sif.sensor;

  ////////////////////////////////////////////////////////////////////////////
  // read data, valid only the cycle after the strobe
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        ssim_pkg::ADDR_STATUS: begin
          rdata_nxt[ssim_pkg::ST_RUN_LSB +: 4] = run_r;
          rdata_nxt[ssim_pkg::ST_FLAG_BIT]     = flag_r;
          rdata_nxt[ssim_pkg::ST_CNT_LSB +: 8] = errcnt_r;
        end
        ssim_pkg::ADDR_VIEW: begin
          rdata_nxt[ssim_pkg::VW_SENS_LSB +: 8] = sif.sensor;
          rdata_nxt[ssim_pkg::VW_REM_LSB +: 8]  = remote_r;
          rdata_nxt[ssim_pkg::VW_SEEN_BIT]      = seen_r;
        end
        // config is write-only; unmapped reads return zero
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata  = rdata_r;
  assign error_stop = stop_r;
  assign error_flag = flag_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_node_port_take: assert property ( // see RULE12
    frame_ok |=> remote_r == $past(rx_port_data[port_sel * 8 +: 8]))
    else $error("remote byte not taken from matching frame");

  a_miss_hold_value: assert property ( // see RULE20
    (!frame_ok) |=> $stable(remote_r))
    else $error("remote byte changed without a frame");

  a_cnt_saturates: assert property ( // see RULE13
    (errcnt_r == 8'hFF && !clr_cmd) |=> errcnt_r == 8'hFF)
    else $error("error counter left saturation");

  a_cnt_clear_cmd: assert property ( // see RULE14
    (clr_cmd && !period_err) |=> errcnt_r == 8'h00)
    else $error("clear command did not zero counter");

  a_cnt_counts_err: assert property ( // see RULE20
    (period_err && !clr_cmd && errcnt_r != 8'hFF) |=> errcnt_r == $past(errcnt_r) + 8'h01)
    else $error("missed period not counted");

  a_limit_zero_off: assert property ( // see RULE15
    (err_limit == 4'h0) |=> !stop_r)
    else $error("error stop with zero limit");

  a_stop_sets_flag: assert property ( // see RULE16
    stop_r |-> (flag_r && $past(period_err) && $past(run_inc) == $past(err_limit)))
    else $error("stop without reaching limit or flag");

  a_good_restart: assert property ( // see RULE17
    (cycle_tick && period_ok) |=> run_r == 4'h0 ##1 (run_r <= 4'h1))
    else $error("consecutive count not restarted");

  a_rdata_one_cyc: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

endmodule : ssim_top

// >>> tb/ssim_node_model.sv
// Purpose: remote io node seen through the cyclic receive path
// Assumes: one own frame and one stranger frame per period
// Notes:   idle lines invert each cycle so stale data is never mistaken
`timescale 1ns/1ns
module ssim_node_model #(
  parameter int PERIOD = 16
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [5:0]  node,
  input  wire logic [31:0] port_data,
  input  wire logic        drop,
  output logic             rx_valid,
  output logic [5:0]       rx_node,
  output logic [31:0]      rx_port_data,
  output logic             cycle_tick
);
  int cnt;
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt          <= 0;
      rx_valid     <= 1'b0;
      rx_node      <= 6'h00;
      rx_port_data <= 32'h0000_0000;
      cycle_tick   <= 1'b0;
    end else begin
      cnt          <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      cycle_tick   <= (cnt == PERIOD - 1);
      // stranger at 4 carries inverted data; own frame at 8 unless dropped
      rx_valid     <= (cnt == 4) || (cnt == 8 && !drop);
      rx_node      <= (cnt == 4) ? node + 6'h01 : (cnt == 8) ? node : ~rx_node;
      rx_port_data <= (cnt == 4) ? ~port_data : (cnt == 8) ? port_data : ~rx_port_data;
    end
  end
endmodule : ssim_node_model

// >>> tb/tb_ssim_top.sv
// Purpose: self-checking bench for the substitute sensor input monitor
// Assumes: frame period of 16 cycles from the node model
// Notes:   reads sample at the falling edge of the answer cycle
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_ssim_top;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [31:0] rdata;
  logic [7:0]  pins  = 8'h00;
  logic [5:0]  node  = 6'h00;
  logic [31:0] pdata = 32'h0000_0000;
  logic        drop  = 1'b0;
  logic        rx_valid, cycle_tick, error_stop, error_flag;
  logic [5:0]  rx_node;
  logic [31:0] rx_port_data, d, nd, seed = 32'h0000_22F6;
  logic [7:0]  sensor_out, sel;
  logic [1:0]  port;
  int          n_mismatch = 0, n_checks = 0, n_stop = 0, cyc = 0;

  always #2 clock = ~clock;

  ssim_top ssim_top_inst (.clock(clock), .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .forward_limit_input(pins[0]),
    .reverse_limit_input(pins[1]), .slowdown_input(pins[2]), .origin_sensor_input(pins[3]),
    .emergency_halt_input(pins[4]), .alarm_input(pins[5]), .external_go_input(pins[6]),
    .external_halt_input(pins[7]), .rx_valid(rx_valid), .rx_node(rx_node),
    .rx_port_data(rx_port_data), .cycle_tick(cycle_tick), .sensor_out(sensor_out),
    .error_stop(error_stop), .error_flag(error_flag));
  ssim_node_model ssim_node_model_inst (.clock(clock), .rst_b(rst_b), .node(node),
    .port_data(pdata), .drop(drop), .rx_valid(rx_valid), .rx_node(rx_node),
    .rx_port_data(rx_port_data), .cycle_tick(cycle_tick));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] cfg(input logic [5:0] n, input logic [1:0] p,
                                      input logic [7:0] s, input logic [3:0] l);
    return (32'(n) << ssim_pkg::NODE_LSB) | (32'(p) << ssim_pkg::PSEL_LSB)
         | (32'(s) << ssim_pkg::SEL_LSB) | (32'(l) << ssim_pkg::LIMIT_LSB);
  endfunction : cfg
  function automatic logic [7:0] exp_sensor(input logic [7:0] s, input logic [31:0] v,
                                            input logic [1:0] p, input logic [7:0] pn);
    logic [31:0] b;
    b = v >> (8 * p);
    return (s & b[7:0]) | (~s & pn);
  endfunction : exp_sensor
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    @(negedge clock);
    v = rdata;
  endtask : rd_reg
  task automatic periods(input int n);
    repeat (n) begin
      @(posedge clock);
      while (cycle_tick !== 1'b1) @(posedge clock);
    end
  endtask : periods
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cyc++;
    if (error_stop === 1'b1) n_stop++;
    // full run needs about 5100 cycles
    if (cyc == 12000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    rd_reg(ssim_pkg::ADDR_STATUS, d);
    `CHK(d, 32'h0000_0000)
    wr_reg(8'h10, 32'hFFFF_FFFF);
    rd_reg(8'h10, d);
    `CHK(d, 32'h0000_0000)
    rd_reg(ssim_pkg::ADDR_CONFIG, d);
    `CHK(d, 32'h0000_0000)
    $display("test reset done");
    // first loop pins and node move on a rising edge; later ones move at the read's sampling point
    @(posedge clock);
    for (int i = 0; i < 16; i++) begin
      nd   = (i == 0) ? 32'h3F : (i == 1) ? 32'h00 : rnd();
      sel  = (i < 4) ? 8'hFF : (i < 12) ? (8'h01 << (i - 4)) : 8'(rnd());
      port = 2'(i);
      node  <= nd[5:0];
      pdata <= rnd();
      pins  <= 8'(rnd());
      wr_reg(ssim_pkg::ADDR_CONFIG, cfg(nd[5:0], port, sel, 4'hF));
      periods(3);
      `CHK(sensor_out, exp_sensor(sel, pdata, port, pins))
      rd_reg(ssim_pkg::ADDR_VIEW, d);
      `CHK(d[15:0], {pdata[8 * port +: 8], exp_sensor(sel, pdata, port, pins)})
    end
    $display("test select done");
    node <= 6'h05;
    wr_reg(ssim_pkg::ADDR_CONFIG, cfg(6'h05, 2'h1, 8'hFF, 4'h3));
    periods(2);
    drop <= 1'b1;
    wr_reg(ssim_pkg::ADDR_COMMAND, {16'h0000, ssim_pkg::CMD_CLR_ERRCNT});
    wr_reg(ssim_pkg::ADDR_STATUS, 32'h0000_0100);
    periods(2);
    rd_reg(ssim_pkg::ADDR_STATUS, d);
    `CHK(d, 32'h0002_0002)
    drop <= 1'b0;
    periods(1);
    drop <= 1'b1;
    rd_reg(ssim_pkg::ADDR_STATUS, d);
    `CHK(d, 32'h0002_0000)
    periods(3);
    rd_reg(ssim_pkg::ADDR_STATUS, d);
    `CHK(d, 32'h0005_0100)
    `CHK(n_stop, 1)
    `CHK(sensor_out, pdata[15:8])
    wr_reg(ssim_pkg::ADDR_STATUS, 32'h0000_0100);
    @(posedge clock);
    `CHK(error_flag, 1'b0)
    $display("test errors done");
    wr_reg(ssim_pkg::ADDR_CONFIG, cfg(6'h05, 2'h1, 8'hFF, 4'h0));
    periods(255);
    rd_reg(ssim_pkg::ADDR_STATUS, d);
    `CHK(d, 32'h00FF_0000)
    `CHK(n_stop, 1)
    wr_reg(ssim_pkg::ADDR_COMMAND, {16'h0000, ssim_pkg::CMD_CLR_ERRCNT});
    rd_reg(ssim_pkg::ADDR_STATUS, d);
    `CHK(d, 32'h0000_0000)
    $display("test saturate done");
    periods(3);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rd_reg(ssim_pkg::ADDR_STATUS, d);
    `CHK(d, 32'h0000_0000)
    $display("test rerun reset done");
    summarize();
  end
endmodule : tb_ssim_top
